// ==== core/rx_emd_pkg.sv ====
// register map, field positions and reset values of the receive emd control block
// assumes an ahb-lite slave with one 32-bit word per register index
package rx_emd_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_EMD_CFG    = 8'h05;
    localparam logic [7:0] IDX_SST        = 8'h06;
    localparam logic [7:0] IDX_RX_CFG1    = 8'h0b;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h11;
    localparam logic [7:0] IDX_OP_CTRL    = 8'h12;
    localparam logic [7:0] IDX_RX_STATUS  = 8'h13;
    // reset values
    localparam logic [7:0] RST_CFG        = 8'h00;
    localparam logic [3:0] RST_IRQ        = 4'h0;
    // emd suppression config fields
    localparam int EMD_EN_BIT   = 7;
    localparam int RX_START_BIT = 6;
    localparam int THLD_MSB     = 3;
    // subcarrier start timer field, quarter etu steps
    localparam int SST_MSB      = 4;
    // receiver config one fields
    localparam int RX_CHANNEL_SELECT_BIT   = 7;
    localparam int LP_MSB       = 6;
    localparam int LP_LSB       = 4;
    // operation control fields
    localparam int OP_DUAL_BIT   = 0;
    localparam int OP_MANUAL_BIT = 1;
    localparam int OP_A106_BIT   = 2;
    localparam int OP_B106_BIT   = 3;
    // interrupt bit positions
    localparam int IRQ_SOFT_ERR = 0;
    localparam int IRQ_RESTART  = 1;
    localparam int IRQ_RX_START = 2;
    localparam int IRQ_EMD      = 3;
    // leading frame bits checked before receive start
    localparam logic [2:0] START_BITS = 3'h4;
    localparam logic [4:0] SST_SAT    = 5'h1f;
endpackage

// ==== core/rx_sst_if.sv ====
// link between the control top and the subcarrier start checker
// assumes both ends on hclk
`timescale 1ns/1ps
interface rx_sst_if;
    logic       mrt_end;      // mask receive timer expiry pulse
    logic       sc_detect;    // subcarrier detected pulse
    logic       quarter_tick; // one pulse per quarter etu
    logic       enable;       // type b 106k active
    logic [4:0] sst;          // programmed start time
    logic       early;        // subcarrier came too soon, pulse
    modport ctrl (output mrt_end, sc_detect, quarter_tick, enable, sst, input early);
    modport chk  (input mrt_end, sc_detect, quarter_tick, enable, sst, output early);
endinterface

// ==== core/sst_check.sv ====
// subcarrier start time checker
// assumes framer strobes are single-cycle pulses on hclk
`timescale 1ns/1ps
module sst_check
    import rx_emd_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    rx_sst_if.chk    sst_io
);
    logic       active;     // window open since timer expiry
    logic [4:0] quarters;   // quarter etu elapsed
    wire        too_soon = active & sst_io.sc_detect & (quarters < sst_io.sst);

    // count quarter etu from timer expiry; the first subcarrier closes the window, the count runs on to saturation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active   <= 1'b0;
            quarters <= 5'h00;
        end else if (!sst_io.enable) begin
            active   <= 1'b0;
        end else if (sst_io.mrt_end) begin
            active   <= 1'b1;
            quarters <= 5'h00;
        end else if (sst_io.sc_detect) begin
            active   <= 1'b0;
        end else if (sst_io.quarter_tick && quarters != SST_SAT) begin
            // saturate: top code can never be beaten by a longer wait
            quarters <= quarters + 5'h01;
        end
    end

    // early flag pulses one cycle after the detect
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sst_io.early <= 1'b0;
        end else begin
            sst_io.early <= sst_io.enable & too_soon;
        end
    end

    chk_early_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        sst_io.early |-> $past(active && sst_io.sc_detect && quarters < sst_io.sst))
        else $error("early flag without a too-soon subcarrier");
    chk_late_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
        (active && sst_io.sc_detect && quarters >= sst_io.sst) |=> !sst_io.early)
        else $error("early flag on an in-time subcarrier");
    cov_early: cover property (@(posedge hclk) disable iff (!hresetn) sst_io.early);
endmodule

// ==== core/rx_emd_ctrl.sv ====
// receive emd suppression, subcarrier start check and channel select control
// assumes ahb-lite master on hclk; framer and analog strobes are hclk pulses
`timescale 1ns/1ps
// Function
// - type a start needs clean first four bits unless start option set
// - short erroneous frame suppressed as disturbance
// - start time five bits, quarter etu steps
// - early subcarrier raises soft error interrupt
// - emd on plus early: suppress, restart interrupt
// - single channel: select bit picks am or pm
// - dual manual: select bit picks framing channel
// - low-pass and zero bits drive analog filter
module rx_emd_ctrl
    import rx_emd_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // receive framer
    input  wire logic        rx_bit_strobe,
    input  wire logic        rx_bit_error,
    input  wire logic        frame_end,
    input  wire logic        frame_error,
    input  wire logic [7:0]  frame_bytes,
    input  wire logic        mask_receive_timer_end,
    input  wire logic        subcarrier_detect,
    input  wire logic        quarter_etu_tick,
    input  wire logic        auto_select_pm,
    output logic             rx_start_ind,
    output logic             frame_deliver,
    output logic             frame_suppress,
    // analog receive channels
    output logic             am_channel_on,
    output logic             pm_channel_on,
    output logic             framing_from_pm,
    output logic [2:0]       lowpass_control,
    output logic             zero_setting_a,
    output logic             zero_setting_b,
    output logic             zero_setting_c,
    output logic             zero_setting_d,
    output logic             irq
);

////////////////////////////////////////////////////////////////////////////////
// registers and bus state

    logic [7:0] emd_suppression_config; // enable, start option, threshold
    logic [7:0] subcarrier_start_timer; // start time in quarter etu
    logic [7:0] receiver_config_one;    // channel select, filter codes
    logic [7:0] op_ctrl;                // channel and protocol mode
    logic [3:0] irq_status;             // sticky events
    logic [3:0] irq_mask;               // one enables the event
    logic       wr_pend;                // write data phase pending
    logic [7:0] wr_idx;                 // latched write index
    logic [2:0] bit_cnt;                // leading bits seen
    logic       bit_err_acc;            // error among leading bits
    logic       sst_fail;               // early subcarrier in this frame
    logic       last_supp;              // last frame outcome
    logic [3:0] next_irq_status;        // status after this edge

    rx_sst_if sst_bus ();

////////////////////////////////////////////////////////////////////////////////
// bus decode

    // only the low ten address bits are decoded; the rest must be zero
    wire        addr_ok   = hsel & htrans[1] & hready;
    wire [7:0]  addr_idx  = haddr[9:2];
    wire        addr_in   = (haddr[31:10] == 22'h000000);
    wire        rd_take   = addr_ok & ~hwrite;
    wire        wr_take   = addr_ok & hwrite & addr_in;
    wire        wr_emd    = wr_pend & (wr_idx == IDX_EMD_CFG);
    wire        wr_sst    = wr_pend & (wr_idx == IDX_SST);
    wire        wr_cfg1   = wr_pend & (wr_idx == IDX_RX_CFG1);
    wire        wr_op     = wr_pend & (wr_idx == IDX_OP_CTRL);
    wire        wr_mask   = wr_pend & (wr_idx == IDX_IRQ_MASK);
    wire        wr_status = wr_pend & (wr_idx == IDX_IRQ_STATUS);
    wire [7:0]  rx_status = {3'h0, last_supp, sst_fail, bit_err_acc, bit_cnt[1:0]};

    // register values after this edge: a read right behind a write
    // must return the new contents, not the old
    // emd config bits 5:4 are reserved, kept zero
    wire [7:0]  next_emd_cfg = wr_emd ? (hwdata[7:0] & 8'hcf) : emd_suppression_config;
    // start timer bits 7:5 are reserved, kept zero
    wire [7:0]  next_sst = wr_sst ? {3'h0, hwdata[SST_MSB:0]} : subcarrier_start_timer;
    wire [7:0]  next_cfg1 = wr_cfg1 ? hwdata[7:0] : receiver_config_one;
    wire [7:0]  next_op = wr_op ? {4'h0, hwdata[3:0]} : op_ctrl;
    wire [3:0]  next_mask = wr_mask ? hwdata[3:0] : irq_mask;

    // read mux, unmapped indices read zero
    wire [7:0] rd_byte =
        !addr_in                        ? 8'h00 :
        (addr_idx == IDX_EMD_CFG)       ? next_emd_cfg :
        (addr_idx == IDX_SST)           ? next_sst :
        (addr_idx == IDX_RX_CFG1)       ? next_cfg1 :
        (addr_idx == IDX_OP_CTRL)       ? next_op :
        (addr_idx == IDX_IRQ_MASK)      ? {4'h0, next_mask} :
        (addr_idx == IDX_IRQ_STATUS)    ? {4'h0, next_irq_status} :
        (addr_idx == IDX_RX_STATUS)     ? rx_status : 8'h00;

////////////////////////////////////////////////////////////////////////////////
// field decode

    wire       emd_en    = emd_suppression_config[EMD_EN_BIT];
    wire       start_opt = emd_suppression_config[RX_START_BIT];
    wire [3:0] emd_thld  = emd_suppression_config[THLD_MSB:0];
    wire       rx_channel_select    = receiver_config_one[RX_CHANNEL_SELECT_BIT];
    wire       dual_on   = op_ctrl[OP_DUAL_BIT];
    wire       manual    = op_ctrl[OP_MANUAL_BIT];
    wire       type_a106 = op_ctrl[OP_A106_BIT];
    wire       type_b106 = op_ctrl[OP_B106_BIT];

    // type a start window: the bit closing the leading group
    wire       lead_bit  = type_a106 & rx_bit_strobe & (bit_cnt < START_BITS);
    wire       lead_last = lead_bit & (bit_cnt == START_BITS - 3'h1);
    wire       lead_bad  = bit_err_acc | rx_bit_error;
    wire       next_start = lead_last & (~lead_bad | start_opt);

    // frame verdict; an early detect in the end cycle still counts
    wire       fail_now   = sst_fail | sst_bus.early;
    wire       short_err  = frame_error & ({4'h0, emd_thld} > frame_bytes);
    wire       next_supp  = frame_end & emd_en & (short_err | fail_now);
    wire       next_deliv = frame_end & ~next_supp;
    wire       restart_ev = frame_end & emd_en & fail_now;
    wire       emd_ev     = frame_end & emd_en & short_err;

    // channel routing
    wire       next_am_on = dual_on | ~rx_channel_select;
    wire       next_pm_on = dual_on | rx_channel_select;
    wire       next_fpm   = (dual_on & ~manual) ? auto_select_pm : rx_channel_select;

    // sticky events, a new event beats a same-cycle clear
    wire [3:0] events     = {emd_ev, next_start, restart_ev, sst_bus.early};
    wire [3:0] w1c        = wr_status ? hwdata[3:0] : 4'h0;
    assign next_irq_status = (irq_status & ~w1c) | events;

////////////////////////////////////////////////////////////////////////////////
// subcarrier start checker

    assign sst_bus.mrt_end      = mask_receive_timer_end;
    assign sst_bus.sc_detect    = subcarrier_detect;
    assign sst_bus.quarter_tick = quarter_etu_tick;
    assign sst_bus.enable       = type_b106;
    assign sst_bus.sst          = subcarrier_start_timer[SST_MSB:0];

    sst_check u_sst (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sst_io  (sst_bus.chk)
    );

////////////////////////////////////////////////////////////////////////////////
// bus slave: zero wait state, always okay

    // address phase latch and registered read data
    // hrdata stands until the next read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_idx    <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= wr_take;
            wr_idx    <= addr_idx;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (rd_take) begin
                hrdata <= {24'h000000, rd_byte};
            end
        end
    end

    // software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            emd_suppression_config <= RST_CFG;
            subcarrier_start_timer <= RST_CFG;
            receiver_config_one    <= RST_CFG;
            op_ctrl                <= RST_CFG;
            irq_mask               <= RST_IRQ;
        end else begin
            // decode and masking live in the next values
            emd_suppression_config <= next_emd_cfg;
            subcarrier_start_timer <= next_sst;
            receiver_config_one    <= next_cfg1;
            op_ctrl                <= next_op;
            irq_mask               <= next_mask;
        end
    end

    // interrupt status and line; the line follows status by one cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= RST_IRQ;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq        <= |(irq_status & irq_mask);
        end
    end

////////////////////////////////////////////////////////////////////////////////
// frame tracking

    // leading bit count and error memory, cleared by frame end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt     <= 3'h0;
            bit_err_acc <= 1'b0;
        end else if (frame_end) begin
            bit_cnt     <= 3'h0;
            bit_err_acc <= 1'b0;
        end else if (lead_bit) begin
            bit_cnt     <= bit_cnt + 3'h1;
            bit_err_acc <= lead_bad;
        end
    end

    // early subcarrier memory lasts to the frame's end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sst_fail  <= 1'b0;
            last_supp <= 1'b0;
        end else begin
            sst_fail <= frame_end ? 1'b0 : fail_now;
            if (frame_end) begin
                last_supp <= next_supp;
            end
        end
    end

    // framer strobes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_start_ind   <= 1'b0;
            frame_deliver  <= 1'b0;
            frame_suppress <= 1'b0;
        end else begin
            rx_start_ind   <= next_start;
            frame_deliver  <= next_deliv;
            frame_suppress <= next_supp;
        end
    end

    // analog controls, registered from the configuration; dual auto framing follows auto_select_pm
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            am_channel_on   <= 1'b0;
            pm_channel_on   <= 1'b0;
            framing_from_pm <= 1'b0;
            lowpass_control <= 3'h0;
            zero_setting_a  <= 1'b0;
            zero_setting_b  <= 1'b0;
            zero_setting_c  <= 1'b0;
            zero_setting_d  <= 1'b0;
        end else begin
            am_channel_on   <= next_am_on;
            pm_channel_on   <= next_pm_on;
            framing_from_pm <= next_fpm;
            lowpass_control <= receiver_config_one[LP_MSB:LP_LSB];
            zero_setting_a  <= receiver_config_one[3];
            zero_setting_b  <= receiver_config_one[2];
            zero_setting_c  <= receiver_config_one[1];
            zero_setting_d  <= receiver_config_one[0];
        end
    end

////////////////////////////////////////////////////////////////////////////////
// checks

    chk_start_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
        (lead_last && lead_bad && !start_opt) |=> !rx_start_ind)
        else $error("receive start raised after bad leading bits");

    chk_start_raised: assert property (@(posedge hclk) disable iff (!hresetn)
        (lead_last && (!lead_bad || start_opt)) |=> rx_start_ind)
        else $error("receive start missing");

    chk_short_suppress: assert property (@(posedge hclk) disable iff (!hresetn)
        (frame_end && emd_en && frame_error && frame_bytes < {4'h0, emd_thld})
        |=> frame_suppress && !frame_deliver)
        else $error("short erroneous frame delivered");

    chk_emd_off_deliver: assert property (@(posedge hclk) disable iff (!hresetn)
        (frame_end && !emd_en) |=> frame_deliver && !frame_suppress)
        else $error("frame suppressed with emd off");

    chk_restart_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (frame_end && emd_en && fail_now) |=> frame_suppress && irq_status[IRQ_RESTART])
        else $error("early subcarrier frame not restarted");

    chk_soft_err_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_status[IRQ_SOFT_ERR] && !w1c[IRQ_SOFT_ERR]) |=> irq_status[IRQ_SOFT_ERR])
        else $error("soft error flag lost");

    chk_soft_err_set: assert property (@(posedge hclk) disable iff (!hresetn)
        sst_bus.early |=> irq_status[IRQ_SOFT_ERR])
        else $error("soft error flag not set");

    chk_single_channel: assert property (@(posedge hclk) disable iff (!hresetn)
        !dual_on |=> (am_channel_on == !$past(rx_channel_select)) && (pm_channel_on == $past(rx_channel_select)))
        else $error("single channel select wrong");

    chk_manual_framing: assert property (@(posedge hclk) disable iff (!hresetn)
        (dual_on && manual) |=> framing_from_pm == $past(rx_channel_select))
        else $error("manual framing channel wrong");

    chk_filter_pass: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 lowpass_control == $past(receiver_config_one[LP_MSB:LP_LSB]))
        else $error("low-pass code not passed");

    chk_irq_line: assert property (@(posedge hclk) disable iff (!hresetn)
        |(irq_status & irq_mask) |=> irq)
        else $error("interrupt line low with unmasked flag");

    // start timer reads return what the last write left
    chk_read_fresh: assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_take && addr_in && addr_idx == IDX_SST) |=> hrdata[7:0] == subcarrier_start_timer)
        else $error("start timer read returned stale data");

    // scenarios the bench must reach
    cov_suppress: cover property (@(posedge hclk) disable iff (!hresetn) frame_suppress);
    cov_start: cover property (@(posedge hclk) disable iff (!hresetn) rx_start_ind);
    cov_restart: cover property (@(posedge hclk) disable iff (!hresetn) restart_ev);
endmodule

// ==== tb/framer_model.sv ====
// partner model of the receive framer and analog front end strobes
// assumes the bench calls one task at a time; all strobes are hclk pulses
`timescale 1ns/1ps
module framer_model (
    input  wire logic       hclk,
    output logic            rx_bit_strobe,
    output logic            rx_bit_error,
    output logic            frame_end,
    output logic            frame_error,
    output logic [7:0]      frame_bytes,
    output logic            mask_receive_timer_end,
    output logic            subcarrier_detect,
    output logic            quarter_etu_tick
);
    // all strobes idle low at time zero
    initial begin
        {rx_bit_strobe, rx_bit_error, frame_end, frame_error} = 4'h0;
        {mask_receive_timer_end, subcarrier_detect, quarter_etu_tick} = 3'h0;
        frame_bytes = 8'h00;
    end
    // n bits with one error flag each; qualifiers scrambled between strobes
    task automatic send_bits(input int n, input logic [3:0] errs);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            rx_bit_strobe <= 1'b1;
            rx_bit_error  <= errs[i];
            @(posedge hclk);
            rx_bit_strobe <= 1'b0;
            rx_bit_error  <= ~errs[i];
        end
    endtask
    // timer expiry, q quarter ticks back to back, then subcarrier found
    task automatic sst_run(input int q);
        @(posedge hclk);
        mask_receive_timer_end <= 1'b1;
        for (int i = 0; i < q; i++) begin
            @(posedge hclk);
            mask_receive_timer_end <= 1'b0;
            quarter_etu_tick       <= 1'b1;
        end
        @(posedge hclk);
        {mask_receive_timer_end, quarter_etu_tick} <= 2'b00;
        subcarrier_detect <= 1'b1;
        @(posedge hclk);
        subcarrier_detect <= 1'b0;
    endtask
    // frame end with its qualifiers; the length is not held afterwards
    task automatic fend(input logic err, input logic [7:0] bytes);
        @(posedge hclk);
        {frame_end, frame_error, frame_bytes} <= {1'b1, err, bytes};
        @(posedge hclk);
        {frame_end, frame_error, frame_bytes} <= {1'b0, ~err, ~bytes};
    endtask
endmodule

// ==== tb/test_rx_emd_ctrl.sv ====
// self-checking bench of the receive emd control block over ahb-lite
// assumes zero-wait slave; framer strobes come from the partner model
`timescale 1ns/1ps
module test_rx_emd_ctrl;
    import rx_emd_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic        hreadyout, hresp, auto_select_pm = 1'b0;
    logic        rbs, rbe, fe, ferr, mask_receive_timer, scd, qt, start_ind, deliver, suppress;
    logic [7:0]  fbytes;
    logic        am_on, pm_on, from_pm, za, zb, zc, zd, irq;
    logic [2:0]  lp;
    int          failures = 0, n_checks = 0;
    int          n_start = 0, n_del = 0, n_sup = 0, s0, d0, p0;
    // 200 mhz clock
    always #2.5 hclk = ~hclk;
    // count the one-cycle result pulses so scenarios compare deltas
    always @(posedge hclk) begin
        n_start += start_ind;
        n_del   += deliver;
        n_sup   += suppress;
    end
    ////////////////////////////////////////////////////////////////////////////
    rx_emd_ctrl rx_emd_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_bit_strobe(rbs),
        .rx_bit_error(rbe), .frame_end(fe), .frame_error(ferr), .frame_bytes(fbytes),
        .mask_receive_timer_end(mask_receive_timer), .subcarrier_detect(scd), .quarter_etu_tick(qt),
        .auto_select_pm(auto_select_pm), .rx_start_ind(start_ind), .frame_deliver(deliver),
        .frame_suppress(suppress), .am_channel_on(am_on), .pm_channel_on(pm_on),
        .framing_from_pm(from_pm), .lowpass_control(lp), .zero_setting_a(za),
        .zero_setting_b(zb), .zero_setting_c(zc), .zero_setting_d(zd), .irq(irq));
    framer_model framer_model_i (.hclk(hclk), .rx_bit_strobe(rbs), .rx_bit_error(rbe),
        .frame_end(fe), .frame_error(ferr), .frame_bytes(fbytes), .mask_receive_timer_end(mask_receive_timer),
        .subcarrier_detect(scd), .quarter_etu_tick(qt));
    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic results();
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // single comparison point
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // wait for hready at a rising edge; a hung slave ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            results();
        end
    endtask
    // one single word transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    // read and compare one register
    task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(what, exp, rd);
    endtask
    // result pulse deltas since the last snapshot
    task automatic pulses(input int st, input int dl, input int sp);
        repeat (3) @(posedge hclk);
        check("rx_start_ind", st, n_start - s0);
        check("frame_deliver", dl, n_del - d0);
        check("frame_suppress", sp, n_sup - p0);
        {s0, d0, p0} = {n_start, n_del, n_sup};
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values, unmapped index reads zero with okay
        rchk("emd_cfg", IDX_EMD_CFG, 32'h0);
        rchk("sst", IDX_SST, 32'h0);
        rchk("rx_cfg1", IDX_RX_CFG1, 32'h0);
        rchk("irq_status", IDX_IRQ_STATUS, 32'h0);
        rchk("unmapped", 8'h3f, 32'h0);
        check("hresp", 32'h0, {31'h0, hresp});
        // filter controls follow receiver config one
        bus(1'b1, IDX_RX_CFG1, 32'h5a);
        repeat (2) @(posedge hclk);
        check("filter", 32'h5a, {25'h0, lp, za, zb, zc, zd});
        // channel select: single then dual manual, both select values
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, IDX_OP_CTRL, {30'h0, k[1], k[1]});
            bus(1'b1, IDX_RX_CFG1, {24'h0, k[0], 7'h00});
            repeat (2) @(posedge hclk);
            if (k < 2) check("single ch", {30'h0, ~k[0], k[0]}, {30'h0, am_on, pm_on});
            else check("dual ch", {29'h0, 2'b11, k[0]}, {29'h0, am_on, pm_on, from_pm});
        end
        // dual auto: selector low wins over select bit high
        bus(1'b1, IDX_OP_CTRL, 32'h1);
        repeat (2) @(posedge hclk);
        check("auto ch", 32'h0, {31'h0, from_pm});
        // type a start indication with start option off, with and without a leading bit error
        bus(1'b1, IDX_OP_CTRL, 32'h4);
        {s0, d0, p0} = {n_start, n_del, n_sup};
        framer_model_i.send_bits(4, 4'b1000);
        framer_model_i.fend(1'b0, 8'h02);
        pulses(0, 1, 0);
        framer_model_i.send_bits(4, 4'b0000);
        framer_model_i.fend(1'b0, 8'h02);
        pulses(1, 1, 0);
        // host settings: emd on, start tolerant, threshold four
        bus(1'b1, IDX_EMD_CFG, 32'hc4);
        rchk("emd_cfg", IDX_EMD_CFG, 32'hc4);
        framer_model_i.send_bits(4, 4'b0001);
        pulses(1, 0, 0);
        // short erroneous frames are disturbances, boundary at the threshold
        bus(1'b1, IDX_OP_CTRL, 32'h0);
        bus(1'b1, IDX_IRQ_STATUS, 32'hf);
        framer_model_i.fend(1'b1, 8'h03);
        pulses(0, 0, 1);
        framer_model_i.fend(1'b1, 8'h04);
        pulses(0, 1, 0);
        framer_model_i.fend(1'b0, 8'h01);
        pulses(0, 1, 0);
        rchk("emd status", IDX_IRQ_STATUS, 32'h8);
        // type b early subcarrier: soft error, then restart and suppression
        bus(1'b1, IDX_IRQ_STATUS, 32'hf);
        bus(1'b1, IDX_OP_CTRL, 32'h8);
        bus(1'b1, IDX_SST, 32'h4);
        framer_model_i.sst_run(3);
        framer_model_i.fend(1'b0, 8'h08);
        pulses(0, 0, 1);
        rchk("early status", IDX_IRQ_STATUS, 32'h3);
        check("irq masked", 32'h0, {31'h0, irq});
        bus(1'b1, IDX_IRQ_MASK, 32'h3);
        repeat (2) @(posedge hclk);
        check("irq on", 32'h1, {31'h0, irq});
        bus(1'b1, IDX_IRQ_STATUS, 32'h1);
        rchk("w1c one", IDX_IRQ_STATUS, 32'h2);
        bus(1'b1, IDX_IRQ_STATUS, 32'h2);
        repeat (2) @(posedge hclk);
        check("irq off", 32'h0, {31'h0, irq});
        // exactly on time is not early
        framer_model_i.sst_run(4);
        framer_model_i.fend(1'b0, 8'h08);
        pulses(0, 1, 0);
        rchk("late status", IDX_IRQ_STATUS, 32'h0);
        // top of the five-bit range, emd off: soft error only
        bus(1'b1, IDX_SST, 32'h1f);
        rchk("sst max", IDX_SST, 32'h1f);
        bus(1'b1, IDX_EMD_CFG, 32'h44);
        framer_model_i.sst_run(30);
        framer_model_i.fend(1'b0, 8'h08);
        pulses(0, 1, 0);
        rchk("soft only", IDX_IRQ_STATUS, 32'h1);
        results();
    end
endmodule
